// *** inc/power_run_pkg.sv ***
package power_run_pkg;

   // Clock and documented delay windows
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
   localparam int unsigned STORE_MIN_MS = 120;
   localparam int unsigned STORE_MAX_MS = 930;
   localparam int unsigned HOLD_MIN_MS = 33;
   localparam int unsigned HOLD_MAX_MS = 85;
   localparam int unsigned DROP_MIN_MS = 2200;
   localparam int unsigned DROP_MAX_MS = 4000;
   // Time allowed for the DC supplies to come up after the main contactor
   localparam int unsigned ATTEMPT_MS = 100;

   // Least times rounded down to whole cycles (exact at 50 MHz)
   localparam int unsigned STORE_DLY_CYC = STORE_MIN_MS * CYC_PER_MS;
   localparam int unsigned HOLD_DLY_CYC = HOLD_MIN_MS * CYC_PER_MS;
   localparam int unsigned DROP_DLY_CYC = DROP_MIN_MS * CYC_PER_MS;
   localparam int unsigned ATTEMPT_CYC = ATTEMPT_MS * CYC_PER_MS;

   // Register byte offsets
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CHECKS_OFS = 8'h04;
   localparam logic [7:0] STORE_DLY_OFS = 8'h08;
   localparam logic [7:0] HOLD_DLY_OFS = 8'h0C;
   localparam logic [7:0] DROP_DLY_OFS = 8'h10;

   // Field positions in the check register
   localparam int unsigned IO_CHECK_LSB = 0;
   localparam int unsigned FEED_CHECK_LSB = 8;

   // Power-failure lamp is lit when the mains breaker closes
   localparam logic FAIL_IND_RESET = 1'b1;

   typedef enum logic [2:0] {
      MODE_PROCESS,
      MODE_ADDR_STOP,
      MODE_SINGLE,
      MODE_STOR_DISPLAY,
      MODE_STOR_ALTER,
      MODE_REG_DISPLAY,
      MODE_REG_ALTER
   } mode_t;

   typedef enum logic [1:0] {
      ROUTINE_STOR_DISPLAY,
      ROUTINE_STOR_ALTER,
      ROUTINE_REG_DISPLAY,
      ROUTINE_REG_ALTER
   } routine_t;

   typedef enum logic [2:0] {
      SEQ_OFF,
      SEQ_WAIT_VOLTS,
      SEQ_STORE_WAIT,
      SEQ_HOLD_WAIT,
      SEQ_ON,
      SEQ_STORE_DROP,
      SEQ_FINAL_DROP
   } seq_state_t;

endpackage

// *** logic/console_power_run_control.sv ***
// Behaviour
// RULE_01: System Reset arms supervisor if cool, clears failure
// RULE_02: Power On closes mains; volts good lights, closes I/O
// RULE_03: Storage enable 120 to 930 ms after I/O
// RULE_04: Storage enable drives protect, sets second stage
// RULE_05: Final hold 33 to 85 ms after second stage
// RULE_06: Power Off clears good, hold, failure memory
// RULE_07: Storage enable drops, then second stage, I/O off; code drops storage enable and second stage in the same cycle
// RULE_08: Mains released 2.2 to 4 s later
// RULE_09: Supervisor stays armed after normal power off
// RULE_10: Emergency drops all; reset needs switch restored
// RULE_11: DC loss clears good, hold; lights failure lamp
// RULE_12: Failure lamp held until restore, Off or Reset
// RULE_13: Power On during failure drops supervisor, relights
// RULE_14: On only when off; Off only when on
// RULE_15: Start reset micro-routine once power present
// RULE_16: Stop lamp lit while processing latch off
// RULE_17: Eight errors stop, set check; Reset clears
// RULE_18: I/O Check Reset clears all but feed check; code clears only the I/O check latches, process check stays set
// RULE_19: Start ignored during process check
// RULE_20: Start dispatches fetch or display/alter routine
// RULE_21: Lamp test lights every indicator
// RULE_22: Delays counted in clocks from loadable counts
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/100ps
module console_power_run_control #(
   parameter int unsigned STORE_DLY_CYC = power_run_pkg::STORE_DLY_CYC,
   parameter int unsigned HOLD_DLY_CYC = power_run_pkg::HOLD_DLY_CYC,
   parameter int unsigned DROP_DLY_CYC = power_run_pkg::DROP_DLY_CYC,
   parameter int unsigned ATTEMPT_CYC = power_run_pkg::ATTEMPT_CYC,
   parameter int unsigned N_UNITS = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Operator keys (one-cycle pulses) and switches (levels)
   input wire logic system_reset_key,
   input wire logic power_on_key,
   input wire logic power_off_key,
   input wire logic emergency_off,
   input wire logic io_check_reset_key,
   input wire logic start_key,
   input wire logic lamp_test,
   input wire logic [2:0] mode_switch,
   // Supply sensing
   input wire logic overtemp_fault,
   input wire logic dc_volts_ok,
   // Processor and I/O events
   input wire logic [7:0] process_error,
   input wire logic halt_request,
   input wire logic [N_UNITS-1:0] io_check_event,
   input wire logic [N_UNITS-1:0] feed_check_event,
   input wire logic [N_UNITS-1:0] card_runout_key,
   // Contactors and storage timing
   output logic main_supply_contactor,
   output logic io_supply_contactor,
   output logic outlet_contactor,
   output logic storage_protect,
   // Micro-program engine requests
   output logic reset_routine_start,
   output logic fetch_start,
   output logic routine_start,
   output logic [1:0] routine_sel,
   // Indicators
   output logic power_on_ind,
   output logic power_fail_ind,
   output logic stop_ind,
   output logic process_check_indicator,
   output logic [N_UNITS-1:0] io_check_ind,
   output logic [N_UNITS-1:0] feed_check_ind
);

   power_run_pkg::seq_state_t state_reg;
   logic [31:0] cnt_reg;
   logic supervisor_stage;
   logic power_good_stage;
   logic storage_enable_stage;
   logic second_power_stage;
   logic final_hold_stage;
   logic main_supply_hold;
   logic failure_memory_stage;
   logic fail_lamp_reg;
   logic processing_reg;
   logic process_check_reg;
   logic [N_UNITS-1:0] io_check_reg;
   logic [N_UNITS-1:0] feed_check_reg;
   logic [31:0] store_dly_reg;
   logic [31:0] hold_dly_reg;
   logic [31:0] drop_dly_reg;
   logic cnt_done;
   logic arm_ok;
   logic on_accept;
   logic off_accept;
   logic dc_loss;
   logic start_ok;
   logic any_error;
   power_run_pkg::mode_t mode;

   assign cnt_done = (cnt_reg == 32'h0000_0000);
   assign arm_ok = system_reset_key && !emergency_off && !overtemp_fault;
   // Power counts as on while the power-good stage holds
   assign on_accept = power_on_key && supervisor_stage && !emergency_off &&
                      state_reg == power_run_pkg::SEQ_OFF;     // [RULE_14]
   assign off_accept = power_off_key && power_good_stage &&
                       !emergency_off;                         // [RULE_14]
   assign dc_loss = power_good_stage && !dc_volts_ok && !emergency_off;
   assign any_error = |process_error;
   assign start_ok = start_key && !process_check_reg && !any_error &&
                     state_reg == power_run_pkg::SEQ_ON;       // [RULE_19]
   assign mode = power_run_pkg::mode_t'(mode_switch);

   // Mains and I/O contactors follow the relay stages; outlet contactor always closed
   assign main_supply_contactor = main_supply_hold;             // [RULE_08]
   assign io_supply_contactor = power_good_stage ||
                                second_power_stage;             // [RULE_07]
   assign storage_protect = storage_enable_stage;               // [RULE_04]
   assign outlet_contactor = 1'b1;

   // Supervisor stage; emergency wins over everything
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supervisor_stage <= 1'b0;
      end else if (emergency_off) begin
         supervisor_stage <= 1'b0;                              // [RULE_10]
      end else if (state_reg == power_run_pkg::SEQ_WAIT_VOLTS &&
                   cnt_done && !dc_volts_ok) begin
         supervisor_stage <= 1'b0;                              // [RULE_13]
      end else if (arm_ok) begin
         supervisor_stage <= 1'b1;                              // [RULE_01]
      end
   end

   // Power sequencer; one down-counter times every stage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= power_run_pkg::SEQ_OFF;
         cnt_reg <= 32'h0000_0000;
         power_good_stage <= 1'b0;
         storage_enable_stage <= 1'b0;
         second_power_stage <= 1'b0;
         final_hold_stage <= 1'b0;
         main_supply_hold <= 1'b0;
         reset_routine_start <= 1'b0;
      end else if (emergency_off) begin
         state_reg <= power_run_pkg::SEQ_OFF;                   // [RULE_10]
         cnt_reg <= 32'h0000_0000;
         power_good_stage <= 1'b0;
         storage_enable_stage <= 1'b0;
         second_power_stage <= 1'b0;
         final_hold_stage <= 1'b0;
         main_supply_hold <= 1'b0;
         reset_routine_start <= 1'b0;
      end else begin
         reset_routine_start <= 1'b0;
         if (!cnt_done) begin
            cnt_reg <= cnt_reg - 32'h0000_0001;                 // [RULE_22]
         end
         if (off_accept || dc_loss) begin
            // Shutdown and supply loss share the timed drop-out path
            power_good_stage <= 1'b0;                      // [RULE_06] [RULE_11]
            final_hold_stage <= 1'b0;
            cnt_reg <= store_dly_reg;                           // [RULE_07]
            state_reg <= power_run_pkg::SEQ_STORE_DROP;
         end else begin
            unique case (state_reg)
               power_run_pkg::SEQ_OFF: begin
                  if (on_accept) begin
                     main_supply_hold <= 1'b1;                  // [RULE_02]
                     cnt_reg <= 32'(ATTEMPT_CYC);
                     state_reg <= power_run_pkg::SEQ_WAIT_VOLTS;
                  end
               end
               power_run_pkg::SEQ_WAIT_VOLTS: begin
                  if (dc_volts_ok) begin
                     power_good_stage <= 1'b1;                  // [RULE_02]
                     cnt_reg <= store_dly_reg;                  // [RULE_03]
                     state_reg <= power_run_pkg::SEQ_STORE_WAIT;
                  end else if (cnt_done) begin
                     main_supply_hold <= 1'b0;                  // [RULE_13]
                     state_reg <= power_run_pkg::SEQ_OFF;
                  end
               end
               power_run_pkg::SEQ_STORE_WAIT: begin
                  if (cnt_done) begin
                     storage_enable_stage <= 1'b1;              // [RULE_03]
                     second_power_stage <= 1'b1;                // [RULE_04]
                     cnt_reg <= hold_dly_reg;                   // [RULE_05]
                     state_reg <= power_run_pkg::SEQ_HOLD_WAIT;
                  end
               end
               power_run_pkg::SEQ_HOLD_WAIT: begin
                  if (cnt_done) begin
                     final_hold_stage <= 1'b1;                  // [RULE_05]
                     reset_routine_start <= 1'b1;               // [RULE_15]
                     state_reg <= power_run_pkg::SEQ_ON;
                  end
               end
               power_run_pkg::SEQ_ON: begin
               end
               power_run_pkg::SEQ_STORE_DROP: begin
                  if (cnt_done) begin
                     storage_enable_stage <= 1'b0;              // [RULE_07]
                     second_power_stage <= 1'b0;                // [RULE_07]
                     cnt_reg <= drop_dly_reg;                   // [RULE_08]
                     state_reg <= power_run_pkg::SEQ_FINAL_DROP;
                  end
               end
               power_run_pkg::SEQ_FINAL_DROP: begin
                  if (cnt_done) begin
                     main_supply_hold <= 1'b0;                  // [RULE_08]
                     // Supervisor untouched, so Power On works again
                     state_reg <= power_run_pkg::SEQ_OFF;       // [RULE_09]
                  end
               end
            endcase
         end
      end
   end

   // Failure memory arms once power is good; lamp shows a stored failure
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         failure_memory_stage <= 1'b0;
         fail_lamp_reg <= power_run_pkg::FAIL_IND_RESET;
      end else if (emergency_off) begin
         failure_memory_stage <= 1'b0;                          // [RULE_10]
      end else if (dc_loss && failure_memory_stage) begin
         fail_lamp_reg <= 1'b1;                                 // [RULE_11]
      end else if (state_reg == power_run_pkg::SEQ_WAIT_VOLTS &&
                   cnt_done && !dc_volts_ok) begin
         fail_lamp_reg <= 1'b1;                                 // [RULE_13]
      end else if (off_accept || arm_ok) begin
         failure_memory_stage <= 1'b0;                     // [RULE_06] [RULE_01]
         fail_lamp_reg <= 1'b0;                                 // [RULE_12]
      end else if (state_reg == power_run_pkg::SEQ_WAIT_VOLTS &&
                   dc_volts_ok) begin
         failure_memory_stage <= 1'b1;
         fail_lamp_reg <= 1'b0;                                 // [RULE_12]
      end
   end

   // Processing latch, process check and Start dispatch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         processing_reg <= 1'b0;
         process_check_reg <= 1'b0;
         fetch_start <= 1'b0;
         routine_start <= 1'b0;
         routine_sel <= 2'h0;
      end else begin
         fetch_start <= 1'b0;
         routine_start <= 1'b0;
         // Error set wins over a System Reset in the same cycle
         if (any_error) begin
            process_check_reg <= 1'b1;                          // [RULE_17]
         end else if (system_reset_key) begin
            process_check_reg <= 1'b0;                          // [RULE_17]
         end
         if (any_error || halt_request ||
             state_reg != power_run_pkg::SEQ_ON) begin
            processing_reg <= 1'b0;                             // [RULE_17]
         end else if (start_ok) begin
            unique case (mode)
               power_run_pkg::MODE_PROCESS,
               power_run_pkg::MODE_ADDR_STOP,
               power_run_pkg::MODE_SINGLE: begin
                  processing_reg <= 1'b1;
                  fetch_start <= 1'b1;                          // [RULE_20]
               end
               power_run_pkg::MODE_STOR_DISPLAY: begin
                  processing_reg <= 1'b1;
                  routine_start <= 1'b1;                        // [RULE_20]
                  routine_sel <= power_run_pkg::ROUTINE_STOR_DISPLAY;
               end
               power_run_pkg::MODE_STOR_ALTER: begin
                  processing_reg <= 1'b1;
                  routine_start <= 1'b1;                        // [RULE_20]
                  routine_sel <= power_run_pkg::ROUTINE_STOR_ALTER;
               end
               power_run_pkg::MODE_REG_DISPLAY: begin
                  processing_reg <= 1'b1;
                  routine_start <= 1'b1;                        // [RULE_20]
                  routine_sel <= power_run_pkg::ROUTINE_REG_DISPLAY;
               end
               power_run_pkg::MODE_REG_ALTER: begin
                  processing_reg <= 1'b1;
                  routine_start <= 1'b1;                        // [RULE_20]
                  routine_sel <= power_run_pkg::ROUTINE_REG_ALTER;
               end
               default: begin
                  // Unused switch code: Start has no effect
               end
            endcase
         end
      end
   end

   // Per-unit I/O and feed check latches; a new check beats its clear
   genvar u;
   generate
      for (u = 0; u < N_UNITS; u++) begin : g_unit
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               io_check_reg[u] <= 1'b0;
               feed_check_reg[u] <= 1'b0;
            end else begin
               if (io_check_event[u]) begin
                  io_check_reg[u] <= 1'b1;
               end else if (io_check_reset_key) begin
                  io_check_reg[u] <= 1'b0;                      // [RULE_18]
               end
               if (feed_check_event[u]) begin
                  feed_check_reg[u] <= 1'b1;
               end else if (card_runout_key[u]) begin
                  feed_check_reg[u] <= 1'b0;                    // [RULE_18]
               end
            end
         end
      end
   endgenerate

   // Indicator drivers; lamp test overrides every lamp
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_on_ind <= 1'b0;
         power_fail_ind <= power_run_pkg::FAIL_IND_RESET;
         stop_ind <= 1'b1;
         process_check_indicator <= 1'b0;
         io_check_ind <= '0;
         feed_check_ind <= '0;
      end else begin
         power_on_ind <= lamp_test || io_supply_contactor;      // [RULE_21]
         power_fail_ind <= lamp_test || fail_lamp_reg;          // [RULE_21]
         stop_ind <= lamp_test || !processing_reg;              // [RULE_16]
         process_check_indicator <= lamp_test || process_check_reg;
         io_check_ind <= io_check_reg | {N_UNITS{lamp_test}};
         feed_check_ind <= feed_check_reg | {N_UNITS{lamp_test}};
      end
   end

   // Delay registers; writes take effect at the next load of the counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         store_dly_reg <= 32'(STORE_DLY_CYC);
         hold_dly_reg <= 32'(HOLD_DLY_CYC);
         drop_dly_reg <= 32'(DROP_DLY_CYC);
      end else if (psel && penable && pwrite) begin
         unique case (paddr)
            power_run_pkg::STORE_DLY_OFS: store_dly_reg <= pwdata;
            power_run_pkg::HOLD_DLY_OFS: hold_dly_reg <= pwdata;
            power_run_pkg::DROP_DLY_OFS: drop_dly_reg <= pwdata;
            default: begin
            end
         endcase
      end
   end

   // Read data captured in the setup phase, so the access needs no wait
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         unique case (paddr)
            power_run_pkg::STATUS_OFS:
               prdata <= {22'h00_0000, process_check_reg, processing_reg,
                          fail_lamp_reg, failure_memory_stage,
                          main_supply_hold, final_hold_stage,
                          second_power_stage, storage_enable_stage,
                          power_good_stage, supervisor_stage};
            power_run_pkg::CHECKS_OFS: begin
               prdata <= 32'h0000_0000;
               prdata[power_run_pkg::IO_CHECK_LSB +: N_UNITS] <=
                  io_check_reg;
               prdata[power_run_pkg::FEED_CHECK_LSB +: N_UNITS] <=
                  feed_check_reg;
            end
            power_run_pkg::STORE_DLY_OFS: prdata <= store_dly_reg;
            power_run_pkg::HOLD_DLY_OFS: prdata <= hold_dly_reg;
            power_run_pkg::DROP_DLY_OFS: prdata <= drop_dly_reg;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable &&
                    paddr != power_run_pkg::STATUS_OFS &&
                    paddr != power_run_pkg::CHECKS_OFS &&
                    paddr != power_run_pkg::STORE_DLY_OFS &&
                    paddr != power_run_pkg::HOLD_DLY_OFS &&
                    paddr != power_run_pkg::DROP_DLY_OFS;

   // Age of the power-good stage, read only by the checks below
   logic [31:0] good_age;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_age <= 32'h0000_0000;
      end else if (!power_good_stage) begin
         good_age <= 32'h0000_0000;
      end else if (good_age != 32'hFFFF_FFFF) begin
         good_age <= good_age + 32'h0000_0001;
      end
   end

   arm_needs_cool_a: assert property ( // [RULE_01]
      @(posedge pclk) disable iff (!presetn)
      $rose(supervisor_stage) |->
         $past(system_reset_key && !overtemp_fault && !emergency_off))
      else $error("supervisor armed without a valid reset");

   mains_on_a: assert property ( // [RULE_02]
      @(posedge pclk) disable iff (!presetn)
      on_accept |=> main_supply_contactor ##0 !io_supply_contactor)
      else $error("power on did not close mains alone");

   store_delay_a: assert property ( // [RULE_03]
      @(posedge pclk) disable iff (!presetn)
      $rose(storage_enable_stage) |-> good_age > store_dly_reg)
      else $error("storage enabled before its delay");

   protect_second_a: assert property ( // [RULE_04]
      @(posedge pclk) disable iff (!presetn)
      $rose(storage_enable_stage) |->
         storage_protect && $rose(second_power_stage))
      else $error("storage enable without second stage");

   off_clears_a: assert property ( // [RULE_06]
      @(posedge pclk) disable iff (!presetn)
      off_accept |=>
         !power_good_stage && !final_hold_stage && !failure_memory_stage
         ##1 !fail_lamp_reg)
      else $error("power off left a stage set");

   emergency_drop_a: assert property ( // [RULE_10]
      @(posedge pclk) disable iff (!presetn)
      emergency_off |=> !supervisor_stage && !main_supply_hold &&
         !second_power_stage && !storage_protect)
      else $error("emergency left a stage set");

   fail_lamp_a: assert property ( // [RULE_11]
      @(posedge pclk) disable iff (!presetn)
      dc_loss && failure_memory_stage |=> fail_lamp_reg ##1 power_fail_ind)
      else $error("supply loss did not light failure lamp");

   reset_routine_a: assert property ( // [RULE_15]
      @(posedge pclk) disable iff (!presetn)
      $rose(final_hold_stage) |-> reset_routine_start ##1 !reset_routine_start)
      else $error("reset routine not started once");

   start_ignored_a: assert property ( // [RULE_19]
      @(posedge pclk) disable iff (!presetn)
      start_key && process_check_reg |=> !fetch_start && !routine_start)
      else $error("start taken during process check");

   lamp_test_a: assert property ( // [RULE_21]
      @(posedge pclk) disable iff (!presetn)
      lamp_test |=> power_on_ind && power_fail_ind && stop_ind &&
         process_check_indicator && (&io_check_ind) && (&feed_check_ind))
      else $error("lamp test left a lamp dark");

endmodule // console_power_run_control

// *** bench/console_partner.sv ***
`timescale 1ns/100ps
module console_partner (
   // Supply sense
   input wire logic pclk,
   input wire logic main_supply_contactor,
   output logic dc_volts_ok
);
   logic [2:0] up_reg = 3'h0;
   // Supplies need a few cycles to settle, so volts never follow at once
   always_ff @(posedge pclk) begin
      up_reg <= main_supply_contactor ? up_reg + {2'h0, ~&up_reg} : 3'h0;
   end
   assign dc_volts_ok = &up_reg;
endmodule // console_partner

// *** bench/console_power_run_control_test.sv ***
`timescale 1ns/100ps
module console_power_run_control_test;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
   logic pwrite = 1'h0, lamp_test = 1'h0, dc_volts_ok, pready, pslverr, er;
   logic [4:0] k = 5'h00;
   logic [3:0] iev = 4'h0, ioc;
   logic [2:0] mode_switch = 3'h0;
   logic [7:0] paddr = 8'h00, pe = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [1:0] rsel;
   logic msc, io, sp, rrs, fs, rs, poi, pfi, si, pci, oc;
   logic eo = 1'h0, ot = 1'h0, hr = 1'h0;
   logic [3:0] fev = 4'h0, crk = 4'h0, fci;
   int failures = 0, checked = 0, n;
   always #10 pclk = ~pclk;
   console_partner sup (.pclk, .main_supply_contactor(msc), .dc_volts_ok);
   console_power_run_control #(.STORE_DLY_CYC(20), .HOLD_DLY_CYC(10),
      .DROP_DLY_CYC(30), .ATTEMPT_CYC(15)) DUT (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .system_reset_key(k[0]), .power_on_key(k[1]), .power_off_key(k[2]),
      .io_check_reset_key(k[3]), .start_key(k[4]), .emergency_off(eo),
      .lamp_test, .mode_switch, .overtemp_fault(ot), .dc_volts_ok,
      .process_error(pe), .halt_request(hr), .io_check_event(iev),
      .feed_check_event(fev), .card_runout_key(crk),
      .main_supply_contactor(msc), .io_supply_contactor(io),
      .outlet_contactor(oc), .storage_protect(sp), .reset_routine_start(rrs),
      .fetch_start(fs), .routine_start(rs), .routine_sel(rsel),
      .power_on_ind(poi), .power_fail_ind(pfi), .stop_ind(si),
      .process_check_indicator(pci), .io_check_ind(ioc), .feed_check_ind(fci));
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge pclk) penable <= 1'h1;
      for (n = 0; n < 9 && pready !== 1'h1; n++) @(posedge pclk);
      @(posedge pclk) {rd, er} = {prdata, pslverr};
      chk("pready", 1, n < 9);
      {psel, penable} <= 2'h0;
   endtask
   task automatic press(int i);
      @(posedge pclk) k[i] <= 1'h1;
      @(posedge pclk) k[i] <= 1'h0;
      #1;
   endtask
   task automatic t_up;
      chk("idle", 32'h0000_0003, {msc, pfi, si});
      apb(1'h1, 8'h08, 32'h0000_0014);
      apb(1'h0, 8'h08, 32'h0000_0000);
      chk("store dly", 32'h0000_0014, rd);
      apb(1'h0, 8'h20, 32'h0000_0000);
      chk("slverr", 1, er);
      press(0);
      apb(1'h0, 8'h00, 32'h0000_0000);
      chk("armed", 32'h0000_0001, rd & 32'h0000_0081);
      press(1);
      chk("mains", 1, msc);
      for (n = 0; n < 40 && io !== 1'h1; n++) @(posedge pclk);
      chk("io contactor", 1, io);
      for (n = 0; n < 40 && sp !== 1'h1; n++) @(posedge pclk);
      chk("store wait", 1, n >= 20 && n <= 22);
      for (n = 0; n < 40 && rrs !== 1'h1; n++) @(posedge pclk);
      chk("hold wait", 1, n >= 10 && n <= 12);
      chk("on lamp", 1, poi);
   endtask
   task automatic t_run;
      press(4);
      chk("fetch", 1, fs);
      @(posedge pclk) mode_switch <= 3'h5;
      #1 chk("stop lamp", 0, si);
      press(4);
      chk("routine", 32'h0000_0006, {rs, rsel});
      @(posedge pclk) {pe, iev, fev} <= {8'h80, 4'h3, 4'h1};
      @(posedge pclk) {pe, iev, fev} <= 16'h0000;
      repeat (2) @(posedge pclk);
      #1 chk("checks", 32'h0000_0013, {pci, ioc});
      press(4);
      chk("start refused", 0, fs | rs);
      press(3);
      repeat (2) @(posedge pclk);
      #1 chk("io cleared", 32'h0000_0010, {pci, ioc});
      chk("feed kept", 32'h0000_0001, fci);
      @(posedge pclk) crk <= 4'h1;
      @(posedge pclk) crk <= 4'h0;
      repeat (2) @(posedge pclk);
      #1 chk("feed cleared", 32'h0000_0000, fci);
      @(posedge pclk) lamp_test <= 1'h1;
      repeat (2) @(posedge pclk);
      #1 chk("lamps", 32'h0000_001f, {poi, pfi, si, pci, &ioc});
      @(posedge pclk) lamp_test <= 1'h0;
   endtask
   task automatic t_down;
      press(2);
      for (n = 0; n < 40 && sp !== 1'h0; n++) @(posedge pclk);
      chk("io off", 32'h0000_0000, {sp, io});
      for (n = 0; n < 60 && msc !== 1'h0; n++) @(posedge pclk);
      chk("drop wait", 1, n >= 30 && n <= 32);
      apb(1'h0, 8'h00, 32'h0000_0000);
      chk("still armed", 32'h0000_0001, rd & 32'h0000_00c3);
      chk("outlet", 1, oc);
   endtask
   task automatic t_emer;
      @(posedge pclk) eo <= 1'h1;
      @(posedge pclk) eo <= 1'h0;
      apb(1'h0, 8'h00, 32'h0000_0000);
      chk("emergency", 0, rd[0]);
      @(posedge pclk) ot <= 1'h1;
      press(0);
      apb(1'h0, 8'h00, 32'h0000_0000);
      chk("hot arm", 0, rd[0]);
      @(posedge pclk) ot <= 1'h0;
      press(0);
      apb(1'h0, 8'h00, 32'h0000_0000);
      chk("rearm", 1, rd[0]);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      #1;
      t_up;
      t_run;
      t_down;
      t_emer;
      tally_and_finish;
   end
endmodule // console_power_run_control_test
